// ==== hdl/asp_pkg.sv ====
package asp_pkg;

	// ****************************************
	// Serial control register layout
	// ****************************************
	typedef struct packed {
		logic frame_length_select;    // bit 7
		logic reserved_6;             // bit 6, reads zero
		logic address_filter_enable;  // bit 5
		logic receive_enable_bit;     // bit 4
		logic transmit_ninth_bit;     // bit 3
		logic received_ninth_bit;     // bit 2
		logic transmit_done_flag;     // bit 1
		logic receive_done_flag;      // bit 0
	} asp_ctrl_s;

	localparam asp_ctrl_s CTRL_RESET = 8'h00;

	// ****************************************
	// Baud timer configuration
	// ****************************************
	localparam int TIMER_W = 8;

	typedef struct packed {
		logic               run;
		logic [2:0]         clk_sel;
		logic [TIMER_W-1:0] baud_reload_value;
	} asp_baud_cfg_s;

	localparam logic [2:0] SEL_SYSTEM_CLOCK     = 3'h0;
	localparam logic [2:0] SEL_SYSTEM_CLOCK_D4  = 3'h1;
	localparam logic [2:0] SEL_SYSTEM_CLOCK_D12 = 3'h2;
	localparam logic [2:0] SEL_SYSTEM_CLOCK_D48 = 3'h3;
	localparam logic [2:0] SEL_EXTOSC_D8  = 3'h4;
	localparam logic [2:0] SEL_EXT_INPUT  = 3'h5;

	localparam logic [5:0] PRE_DIV4  = 6'h04;
	localparam logic [5:0] PRE_DIV12 = 6'h0c;
	localparam logic [5:0] PRE_DIV48 = 6'h30;
	localparam logic [2:0] EXT_DIV8  = 3'h7;  // Terminal count of the divide-by-8

	localparam logic [2:0] DATA_BITS_LAST = 3'h7;

endpackage : asp_pkg

// ==== hdl/asp_reload_timer.sv ====
`timescale 1ns/1ps
module asp_reload_timer #(
	parameter int WIDTH = 8
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_tick,
	input  wire logic             i_force,
	input  wire logic [WIDTH-1:0] i_reload,
	output logic                  o_overflow,
	output logic      [WIDTH-1:0] o_count
);

	if (WIDTH < 2) begin : g_bad_width
		$error("asp_reload_timer: WIDTH must be at least 2");
	end

	// Forced reload beats a coincident overflow
	assign o_overflow = i_tick & ~i_force & (o_count == {WIDTH{1'b1}});

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_count <= '0;
		end else if (i_force) begin
			o_count <= i_reload;
		end else if (i_tick) begin
			if (o_count == {WIDTH{1'b1}}) begin
				o_count <= i_reload;
			end else begin
				o_count <= o_count + 1'b1;
			end
		end
	end

endmodule : asp_reload_timer

// ==== hdl/asp_serial_port.sv ====
`timescale 1ns/1ps
// Summary of operation
// R1 - Data write loads transmitter; data read returns receive buffer; transmitter never readable.
// R2 - Completed byte is buffered so next reception proceeds before software reads.
// R3 - Transmit and receive done flags stay set until software writes them clear.
// R4 - Bit timing from 8-bit auto-reload overflows, halved separately for transmit and receive.
// R5 - Hidden receive timer runs with baud timer, shares reload, reloads on start.
// R6 - Overflow rate is timer clock over 256 minus reload; set for twice baud.
// R7 - Timer clock selects system clock, /4, /12, /48, oscillator /8 or input.
// R8 - Control bit 7 selects 8-bit or 9-bit frames.
// R9 - 8-bit frame: start, eight data bits LSB first, stop; ten bits total.
// R10 - Data write starts transmit; done flag sets at start of stop bit.
// R11 - Reception only while receive enable, control bit 4, is one.
// R12 - 8-bit: store byte, stop bit to ninth field, set done if allowed.
// R13 - On overrun buffer keeps first byte; overrunning frame data is lost.
// R14 - 9-bit frame: start, eight data, software ninth bit, stop; eleven bits.
// R15 - 9-bit: ninth bit to ninth field, stop ignored, filter on ninth bit.
// R16 - Interrupt requested when enabled and either done flag is set.
// R17 - Address bytes carry ninth bit one; filter bit 5 passes address bytes only.
// R18 - Line idles high; start bit low, stop bit high.
// R19 - Reset clears control bits and flags and drives transmit idle high.
module asp_serial_port
	import asp_pkg::*;
(
	input  wire logic           i_core_clk,
	input  wire logic           i_rst_n,
	input  wire logic           i_data_wr,
	input  wire logic [7:0]     i_data_wdata,
	input  wire logic           i_ctrl_wr,
	input  wire asp_ctrl_s      i_ctrl_wdata,
	input  wire asp_baud_cfg_s  i_baud_cfg,
	input  wire logic           i_ext_osc_tick,
	input  wire logic           i_baud_timer_ext_input,
	input  wire logic           i_irq_en,
	input  wire logic           i_serial_rx_pin,
	output logic                o_serial_tx_pin,
	output logic [7:0]          o_serial_data_buffer,
	output asp_ctrl_s           o_serial_control_reg,
	output logic                o_irq
);

	// ****************************************
	// Timer clock selection
	// ****************************************
	typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_NINTH, TX_STOP} asp_tx_e;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} asp_rx_e;

	asp_ctrl_s  ctrl;
	logic [5:0] pre_cnt;
	logic [2:0] ext_cnt;
	logic       timer_tick;
	logic       tx_ov;
	logic       rx_ov;
	logic [7:0] rx_timer_count;
	logic       tx_half;
	logic       rx_half;
	logic       tx_bit_tick;
	logic       rx_sample;
	logic       start_det;

	assign ctrl = o_serial_control_reg;

	// One shared prescaler; 48 is a multiple of 4 and 12 so all taps stay even
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			pre_cnt <= 6'h00;
		end else if (pre_cnt == PRE_DIV48 - 6'h01) begin
			pre_cnt <= 6'h00;
		end else begin
			pre_cnt <= pre_cnt + 6'h01;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			ext_cnt <= 3'h0;
		end else if (i_ext_osc_tick) begin
			ext_cnt <= ext_cnt + 3'h1;
		end
	end

	always_comb begin
		case (i_baud_cfg.clk_sel)  // see R7
			SEL_SYSTEM_CLOCK:     timer_tick = 1'b1;
			SEL_SYSTEM_CLOCK_D4:  timer_tick = (6'(pre_cnt % PRE_DIV4) == PRE_DIV4 - 6'h01);
			SEL_SYSTEM_CLOCK_D12: timer_tick = (6'(pre_cnt % PRE_DIV12) == PRE_DIV12 - 6'h01);
			SEL_SYSTEM_CLOCK_D48: timer_tick = (pre_cnt == PRE_DIV48 - 6'h01);
			SEL_EXTOSC_D8:  timer_tick = i_ext_osc_tick && (ext_cnt == EXT_DIV8);
			SEL_EXT_INPUT:  timer_tick = i_baud_timer_ext_input;
			default:        timer_tick = 1'b0;
		endcase
	end

	// ****************************************
	// Baud timers
	// ****************************************
	// Count up to all ones then reload: period is 256 minus reload ticks
	asp_reload_timer #(.WIDTH(TIMER_W)) u_tx_timer (  // see R4, R6
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_tick     (timer_tick & i_baud_cfg.run),
		.i_force    (1'b0),
		.i_reload   (i_baud_cfg.baud_reload_value),
		.o_overflow (tx_ov),
		.o_count    ()
	);

	asp_reload_timer #(.WIDTH(TIMER_W)) u_rx_timer (  // see R5
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_tick     (timer_tick & i_baud_cfg.run),
		.i_force    (start_det),
		.i_reload   (i_baud_cfg.baud_reload_value),
		.o_overflow (rx_ov),
		.o_count    (rx_timer_count)
	);

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			tx_half <= 1'b0;
		end else if (tx_ov) begin
			tx_half <= ~tx_half;  // see R4
		end
	end

	// Restarting the halving at the start edge puts samples at bit centres
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			rx_half <= 1'b0;
		end else if (start_det) begin
			rx_half <= 1'b0;  // see R5
		end else if (rx_ov) begin
			rx_half <= ~rx_half;  // see R4
		end
	end

	assign tx_bit_tick = tx_ov & tx_half;
	assign rx_sample   = rx_ov & ~rx_half;

	// ****************************************
	// Transmitter
	// ****************************************
	asp_tx_e    tx_state;
	logic [7:0] tx_shift;
	logic [2:0] tx_cnt;
	logic       tx_mode9;
	logic       tx_ninth;
	logic       tx_done_set;

	assign tx_done_set = tx_bit_tick && ((tx_state == TX_NINTH) ||
		(tx_state == TX_DATA && tx_cnt == DATA_BITS_LAST && !tx_mode9));

	// Writes while a frame is in flight are dropped
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			tx_state        <= TX_IDLE;
			tx_shift        <= 8'h00;
			tx_cnt          <= 3'h0;
			tx_mode9        <= 1'b0;
			tx_ninth        <= 1'b0;
			o_serial_tx_pin <= 1'b1;  // see R19
		end else begin
			case (tx_state)
				TX_IDLE: begin
					o_serial_tx_pin <= 1'b1;  // see R18
					if (i_data_wr) begin
						tx_shift <= i_data_wdata;  // see R1, R10
						tx_mode9 <= ctrl.frame_length_select;  // see R8
						tx_ninth <= ctrl.transmit_ninth_bit;  // see R14
						tx_state <= TX_WAIT;
					end
				end
				TX_WAIT: if (tx_bit_tick) begin
					o_serial_tx_pin <= 1'b0;  // see R18
					tx_state        <= TX_START;
				end
				TX_START: if (tx_bit_tick) begin
					o_serial_tx_pin <= tx_shift[0];  // see R9
					tx_cnt          <= 3'h0;
					tx_state        <= TX_DATA;
				end
				TX_DATA: if (tx_bit_tick) begin
					if (tx_cnt == DATA_BITS_LAST) begin
						o_serial_tx_pin <= tx_mode9 ? tx_ninth : 1'b1;  // see R14
						tx_state        <= tx_mode9 ? TX_NINTH : TX_STOP;
					end else begin
						o_serial_tx_pin <= tx_shift[1];
						tx_shift        <= {1'b0, tx_shift[7:1]};
						tx_cnt          <= tx_cnt + 3'h1;
					end
				end
				TX_NINTH: if (tx_bit_tick) begin
					o_serial_tx_pin <= 1'b1;
					tx_state        <= TX_STOP;
				end
				TX_STOP: if (tx_bit_tick) begin
					o_serial_tx_pin <= 1'b1;
					tx_state        <= TX_IDLE;
				end
				default: begin
					o_serial_tx_pin <= 1'b1;
					tx_state        <= TX_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	asp_rx_e    rx_state;
	logic [7:0] rx_shift;
	logic [2:0] rx_cnt;
	logic       rx_mode9;
	logic       rx_ninth;
	logic       rx_prev;
	logic       rx_ninth_val;
	logic       rx_load;

	assign start_det    = (rx_state == RX_IDLE) && ctrl.receive_enable_bit &&
		rx_prev && !i_serial_rx_pin;  // see R11
	assign rx_ninth_val = rx_mode9 ? rx_ninth : i_serial_rx_pin;  // see R12, R15
	assign rx_load      = rx_sample && (rx_state == RX_STOP) && !ctrl.receive_done_flag &&
		(!ctrl.address_filter_enable || rx_ninth_val);  // see R13, R17

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			rx_prev <= 1'b1;
		end else begin
			rx_prev <= i_serial_rx_pin;
		end
	end

	// Separate shifter lets a new frame arrive while the buffer is unread
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			rx_state <= RX_IDLE;
			rx_shift <= 8'h00;
			rx_cnt   <= 3'h0;
			rx_mode9 <= 1'b0;
			rx_ninth <= 1'b0;
		end else begin
			case (rx_state)
				RX_IDLE: if (start_det) begin
					rx_mode9 <= ctrl.frame_length_select;  // see R8
					rx_state <= RX_START;
				end
				RX_START: if (rx_sample) begin
					// A glitch that is high again at mid-bit is not a start
					rx_state <= i_serial_rx_pin ? RX_IDLE : RX_DATA;
					rx_cnt   <= 3'h0;
				end
				RX_DATA: if (rx_sample) begin
					rx_shift <= {i_serial_rx_pin, rx_shift[7:1]};  // see R9, R2
					rx_cnt   <= rx_cnt + 3'h1;
					if (rx_cnt == DATA_BITS_LAST) begin
						rx_state <= rx_mode9 ? RX_NINTH : RX_STOP;
					end
				end
				RX_NINTH: if (rx_sample) begin
					rx_ninth <= i_serial_rx_pin;  // see R15
					rx_state <= RX_STOP;
				end
				RX_STOP: if (rx_sample) begin
					rx_state <= RX_IDLE;
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_serial_data_buffer <= 8'h00;
		end else if (rx_load) begin
			o_serial_data_buffer <= rx_shift;  // see R1, R2, R12
		end
	end

	// ****************************************
	// Control register and interrupt
	// ****************************************
	// Hardware sets are applied after the software write so a set wins
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_serial_control_reg <= CTRL_RESET;  // see R19
		end else begin
			if (i_ctrl_wr) begin
				o_serial_control_reg            <= i_ctrl_wdata;  // see R3
				o_serial_control_reg.reserved_6 <= 1'b0;
			end
			if (tx_done_set) begin
				o_serial_control_reg.transmit_done_flag <= 1'b1;  // see R10
			end
			if (rx_load) begin
				o_serial_control_reg.receive_done_flag  <= 1'b1;  // see R12, R15
				o_serial_control_reg.received_ninth_bit <= rx_ninth_val;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= i_irq_en & (ctrl.transmit_done_flag | ctrl.receive_done_flag);  // see R16
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_tx_idle_high: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)  // see R18
		(tx_state == TX_IDLE || tx_state == TX_STOP) |-> o_serial_tx_pin)
		else $error("transmit line not high while idle or stop");

	a_tx_done_stop: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)  // see R10
		$rose(tx_state == TX_STOP) |-> ctrl.transmit_done_flag)
		else $error("transmit done not set at stop bit");

	a_write_starts_tx: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)  // see R10
		(i_data_wr && tx_state == TX_IDLE) |=> (tx_state == TX_WAIT && tx_shift == $past(i_data_wdata)))
		else $error("data write did not start transmit");

	a_flags_sticky: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)  // see R3
		(ctrl.receive_done_flag && !i_ctrl_wr) |=> ctrl.receive_done_flag)
		else $error("receive done cleared without write");

	a_overrun_keeps: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)  // see R13
		ctrl.receive_done_flag |=> $stable(o_serial_data_buffer))
		else $error("buffer overwritten while receive done set");

	a_rx_needs_en: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)  // see R11
		(rx_state == RX_IDLE && !ctrl.receive_enable_bit) |=> rx_state == RX_IDLE)
		else $error("reception started while disabled");

	a_filter_ninth: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)  // see R17
		(rx_load && ctrl.address_filter_enable) |=> o_serial_control_reg.received_ninth_bit)
		else $error("filtered frame accepted with ninth bit zero");

	a_rx_reload: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)  // see R5
		start_det |=> (rx_timer_count == $past(i_baud_cfg.baud_reload_value) && !rx_half))
		else $error("receive timer not reloaded on start");

	a_irq_follows: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)  // see R16
		(i_irq_en && (ctrl.transmit_done_flag || ctrl.receive_done_flag)) |=> o_irq)
		else $error("interrupt not raised for set flag");

	a_reset_idle: assert property (@(posedge i_core_clk)  // see R19
		!i_rst_n |=> (o_serial_tx_pin && o_serial_control_reg == CTRL_RESET))
		else $error("reset did not clear port");

endmodule : asp_serial_port

// ==== testbench/asp_remote_uart.sv ====
`timescale 1ns/1ps
// ****************************************
// Remote serial port model
// ****************************************
module asp_remote_uart #(
	parameter int BIT = 8
) (
	input  wire logic i_core_clk,
	input  wire logic i_line_in,
	input  wire logic i_nine,
	output logic      o_line_out
);
	logic [9:0] got;
	logic [8:0] rx_word;
	logic       rx_stop;
	logic       nine;
	int         rx_cnt;
	initial begin
		o_line_out = 1'b1;
		rx_cnt = 0;
	end
	// Whole frame at a fixed bit time, stop bit left high as idle
	task automatic send_frame(input logic [8:0] word, input logic nine9);
		logic [10:0] frame;
		frame = nine9 ? {1'b1, word, 1'b0} : {2'b11, word[7:0], 1'b0};
		for (int i = 0; i < (nine9 ? 11 : 10); i++) begin
			@(posedge i_core_clk);
			#1 o_line_out = frame[i];
			repeat (BIT - 1) @(posedge i_core_clk);
		end
	endtask : send_frame
	// Centre sampling; start bit itself is not judged here
	always begin
		@(negedge i_line_in);
		nine = i_nine;
		repeat (BIT / 2) @(posedge i_core_clk);
		for (int i = 0; i < (nine ? 10 : 9); i++) begin
			repeat (BIT) @(posedge i_core_clk);
			got[i] = i_line_in;
		end
		rx_word = got[8:0];
		rx_stop = nine ? got[9] : got[8];
		rx_cnt++;
	end
endmodule : asp_remote_uart

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	import asp_pkg::*;
	logic          clk;
	logic          rst_n;
	logic          data_wr;
	logic [7:0]    wdata;
	logic          ctrl_wr;
	asp_ctrl_s     cw;
	asp_baud_cfg_s cfg;
	logic          irq_en;
	logic          nine_mode;
	logic          rx_pin;
	logic          tx_pin;
	logic [7:0]    rbuf;
	asp_ctrl_s     ctrl;
	logic          irq;
	logic          ext_tick;
	int            error_cnt;
	int            tests_run;
	int            cyc;
	// ****************************************
	// Clock, device and far end
	// ****************************************
	initial clk = 1'b0;
	always #20 clk = ~clk;
	// One pulse every other cycle feeds both external timer sources
	always @(posedge clk) #1 ext_tick = ~ext_tick;
	asp_serial_port u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_data_wr(data_wr), .i_data_wdata(wdata),
		.i_ctrl_wr(ctrl_wr), .i_ctrl_wdata(cw), .i_baud_cfg(cfg), .i_ext_osc_tick(ext_tick),
		.i_baud_timer_ext_input(ext_tick), .i_irq_en(irq_en), .i_serial_rx_pin(rx_pin),
		.o_serial_tx_pin(tx_pin), .o_serial_data_buffer(rbuf), .o_serial_control_reg(ctrl), .o_irq(irq));
	asp_remote_uart #(.BIT(8)) u_remote (.i_core_clk(clk), .i_line_in(tx_pin), .i_nine(nine_mode),
		.o_line_out(rx_pin));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, seen);
			error_cnt++;
		end
	endtask : check
	task automatic set_ctrl(input asp_ctrl_s v);
		@(posedge clk);
		#1 ctrl_wr = 1'b1;
		cw = v;
		@(posedge clk);
		#1 ctrl_wr = 1'b0;
	endtask : set_ctrl
	// Write, catch the done flag at the stop edge, then judge the wire
	task automatic tx_frame(input logic [7:0] b, input logic nb);
		int n;
		n = u_remote.rx_cnt;
		@(posedge clk);
		#1 data_wr = 1'b1;
		wdata = b;
		@(posedge clk);
		#1 data_wr = 1'b0;
		for (int i = 0; i < 400 && ctrl.transmit_done_flag !== 1'b1; i++) @(posedge clk);
		check("tx done", ctrl.transmit_done_flag, 1);
		check("stop level", tx_pin, 1);
		check("frame pending", u_remote.rx_cnt == n, 1);
		repeat (2) @(posedge clk);
		check("irq", irq, 1);
		for (int i = 0; i < 200 && u_remote.rx_cnt == n; i++) @(posedge clk);
		check("tx word", u_remote.rx_word, nine_mode ? {nb, b} : {1'b1, b});
		check("tx stop", u_remote.rx_stop, 1);
		check("tx done held", ctrl.transmit_done_flag, 1);
		set_ctrl('0);
		repeat (2) @(posedge clk);
		check("tx done clear", ctrl.transmit_done_flag, 0);
		check("irq clear", irq, 0);
	endtask : tx_frame
	task automatic rx_frame(input logic [8:0] w, input logic [7:0] eb, input logic [1:0] ef);
		u_remote.send_frame(w, nine_mode);
		repeat (8) @(posedge clk);
		check("rx buffer", rbuf, eb);
		check("rx flags", {ctrl.received_ninth_bit, ctrl.receive_done_flag}, ef);
	endtask : rx_frame
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		check("tx idle", tx_pin, 1);
		check("ctrl", ctrl, 0);
		check("buffer", rbuf, 0);
		check("irq", irq, 0);
	endtask : t_reset
	task automatic t_tx;
		nine_mode = 1'b0;
		tx_frame(8'ha5, 1'b0);
		nine_mode = 1'b1;
		set_ctrl(8'h88);
		tx_frame(8'h5a, 1'b1);
		set_ctrl(8'h80);
		tx_frame(8'h3c, 1'b0);
		nine_mode = 1'b0;
	endtask : t_tx
	// Divide-by-4 with reload ff gives the same 8-cycle bit
	task automatic t_div4;
		@(posedge clk);
		#1 cfg = {1'b1, SEL_SYSTEM_CLOCK_D4, 8'hff};
		repeat (20) @(posedge clk);
		tx_frame(8'hc6, 1'b0);
		@(posedge clk);
		#1 cfg = {1'b1, SEL_SYSTEM_CLOCK, 8'hfc};
		repeat (20) @(posedge clk);
	endtask : t_div4
	// Start bit of an all-ones byte lasts exactly one bit time; interrupt masked meanwhile
	task automatic t_clk_src(input logic [2:0] sel, input logic [7:0] reload, input int bit_len);
		int n;
		@(posedge clk);
		#1 cfg = {1'b1, sel, reload};
		irq_en = 1'b0;
		repeat (250) @(posedge clk);
		#1 data_wr = 1'b1;
		wdata = 8'hff;
		@(posedge clk);
		#1 data_wr = 1'b0;
		n = 0;
		for (int i = 0; i < 400 && tx_pin !== 1'b0; i++) @(posedge clk);
		for (int i = 0; i < 400 && tx_pin === 1'b0; i++) begin
			@(posedge clk);
			n++;
		end
		check("bit time", 9'(n), 9'(bit_len));
		for (int i = 0; i < 2000 && ctrl.transmit_done_flag !== 1'b1; i++) @(posedge clk);
		repeat (2) @(posedge clk);
		check("tx done src", ctrl.transmit_done_flag, 1);
		check("irq masked", irq, 0);
		repeat (bit_len) @(posedge clk);
		set_ctrl('0);
		@(posedge clk);
		#1 cfg = {1'b1, SEL_SYSTEM_CLOCK, 8'hfc};
		irq_en = 1'b1;
		repeat (20) @(posedge clk);
	endtask : t_clk_src
	task automatic t_rx8;
		set_ctrl(8'h00);
		rx_frame(9'h03c, 8'h00, 2'b00);
		set_ctrl(8'h10);
		rx_frame(9'h03c, 8'h3c, 2'b11);
		rx_frame(9'h0c3, 8'h3c, 2'b11);
		set_ctrl(8'h30);
		rx_frame(9'h081, 8'h81, 2'b11);
	endtask : t_rx8
	task automatic t_rx9;
		nine_mode = 1'b1;
		set_ctrl(8'hb0);
		rx_frame(9'h055, 8'h81, 2'b00);
		rx_frame(9'h1aa, 8'haa, 2'b11);
		set_ctrl(8'h90);
		rx_frame(9'h066, 8'h66, 2'b01);
		nine_mode = 1'b0;
	endtask : t_rx9
	task automatic final_report;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report
	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			final_report();
		end
	end
	initial begin
		error_cnt = 0;
		tests_run = 0;
		cyc = 0;
		rst_n = 1'b0;
		data_wr = 1'b0;
		wdata = 8'h00;
		ctrl_wr = 1'b0;
		cw = '0;
		cfg = {1'b1, SEL_SYSTEM_CLOCK, 8'hfc};
		irq_en = 1'b1;
		nine_mode = 1'b0;
		ext_tick = 1'b0;
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		t_reset();
		t_tx();
		t_div4();
		t_clk_src(SEL_SYSTEM_CLOCK_D12, 8'hfe, 48);
		t_clk_src(SEL_SYSTEM_CLOCK_D48, 8'hff, 96);
		t_clk_src(SEL_EXTOSC_D8, 8'hff, 32);
		t_clk_src(SEL_EXT_INPUT, 8'hfe, 8);
		t_rx8();
		t_rx9();
		final_report();
	end
endmodule : tb_top
